/* inc/rsc_pkg.sv */
/*
 * Constants for the reset source controller: reset cause flag layout,
 * clock monitor enable position, external reset pulse time.
 * Assumes a single system clock running at 250 MHz.
 */
package rsc_pkg;
	localparam int unsigned CLK_MHZ = 250;
	// least external reset low time, microseconds
	localparam int unsigned EXT_RST_MIN_US = 10;
	// least time in whole cycles: microseconds times CLK_MHZ
	localparam int unsigned EXT_RST_MIN_CYC = EXT_RST_MIN_US * CLK_MHZ;
	localparam int unsigned FLAG_W = 8;
	localparam int unsigned CAUSE_WDT = 0;
	localparam int unsigned CAUSE_CLKMON = 1;
	localparam int unsigned CAUSE_SVD = 2;
	localparam int unsigned CLKMON_EN_BIT = 0;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
	localparam int unsigned SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		RSC_RUN    = 2'b00,
		RSC_HOLD   = 2'b01,
		RSC_RELEASE = 2'b10
	} rsc_state_e;
endpackage

/* verilog/rsc_pin_sync.sv */
/*
 * Three-stage synchroniser with agreement filter for an external pin.
 * Assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic pinIn,
	output logic      pinOut
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	always_comb begin
		stage_d = {stage_q[1:0], pinIn};
		// first stage is read only by the second
		level_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : level_q;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stage_q <= {3{RESET_VAL}};
			level_q <= RESET_VAL;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign pinOut = level_q;
endmodule
`default_nettype wire

/* verilog/rsc_reset_ctrl.sv */
/*
 * Reset source controller: combines the external reset pin with supply
 * detector, watchdog and clock monitor sources (power-on-clear resets only its own registers); gates
 * oscillators, sets pin defaults, records reset causes and holds the
 * sticky clock monitor enable.
 * Assumes rstn is the power-on-clear reset and internal sources are
 * synchronous one-or-more-cycle levels on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl
	import rsc_pkg::*;
#(
	parameter int unsigned PORT_W  = 8,
	parameter int unsigned LOW_PIN = 0,
	parameter int unsigned MIN_CYC = EXT_RST_MIN_CYC
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	input  wire logic                    extResetPinN,
	input  wire logic                    supplyDetReset,
	input  wire logic                    watchdogOverflow,
	input  wire logic                    clockMonFail,
	input  wire logic                    standbyActive,
	input  wire logic                    clkMonWrite,
	input  wire logic                    clkMonWdata,
	output logic                         sysResetN,
	output logic                         watchdogResetN,
	output logic                         supplyDetResetN,
	output logic                         standbyHold,
	output logic                         crystalMainClockEn,
	output logic                         internalRingOscillatorEn,
	output logic [PORT_W-1:0]            portOutEnN,
	output logic [PORT_W-1:0]            portOutForce,
	output logic                         clockMonitorEnable,
	output logic [rsc_pkg::FLAG_W-1:0]   resetCauseFlags
);
	import rsc_pkg::*;

	// the filter counts its first low sample on entry, so one cycle cannot be served
	if (LOW_PIN >= PORT_W) begin : gLowPinCheck
		$error("LOW_PIN outside port");
	end
	if (MIN_CYC < 2) begin : gMinCycCheck
		$error("MIN_CYC must be at least 2");
	end

	localparam int unsigned CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

	logic pinN;
	rsc_pin_sync #(.RESET_VAL(1'b1)) uPinSync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pinIn   (extResetPinN),
		.pinOut  (pinN)
	);

	rsc_state_e           state_q, state_d;
	logic [CW-1:0]        cnt_q, cnt_d;
	logic                 clkEn_q, clkEn_d;
	logic [FLAG_W-1:0]    flags_q, flags_d;
	logic                 intReset;
	logic [CW-1:0]        lowRun_q, lowRun_d;

	assign intReset  = supplyDetReset | watchdogOverflow | clockMonFail;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			// short glitches below the minimum width are not taken as a reset
			RSC_RUN: begin
				cnt_d = '0;
				if (!pinN) begin
					state_d = RSC_HOLD;
					cnt_d   = CW'(1);
				end
			end
			RSC_HOLD: begin
				if (pinN) begin
					state_d = RSC_RUN;
				end else if (cnt_q == CNT_MAX - CW'(1)) begin
					state_d = RSC_RELEASE;
				end else begin
					cnt_d = cnt_q + CW'(1);
				end
			end
			RSC_RELEASE: begin
				if (pinN) state_d = RSC_RUN;
			end
			default: state_d = RSC_RUN;
		endcase
	end

	wire extReset = (state_q == RSC_RELEASE);

	always_comb begin
		clkEn_d = clkEn_q;
		flags_d = flags_q;
		if (clkMonWrite && clkMonWdata) clkEn_d = 1'b1;
		if (watchdogOverflow) flags_d[CAUSE_WDT] = 1'b1;
		if (supplyDetReset) flags_d[CAUSE_SVD] = 1'b1;
		if (clockMonFail) begin
			clkEn_d = 1'b0;
			flags_d[CAUSE_CLKMON] = 1'b1;
		end else if (extReset || supplyDetReset || watchdogOverflow) begin
			clkEn_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= RSC_RUN;
			cnt_q   <= '0;
			clkEn_q <= 1'b0;
			flags_q <= FLAGS_RESET;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			clkEn_q <= clkEn_d;
			flags_q <= flags_d;
		end
	end

	// the detector is kept out of its own reset to avoid a latch-up loop
	always_comb begin
		sysResetN                = ~(extReset | intReset);
		watchdogResetN           = ~(extReset | intReset);
		supplyDetResetN          = ~extReset;
		crystalMainClockEn       = ~extReset;
		internalRingOscillatorEn = ~extReset;
		standbyHold              = standbyActive & extReset;
		portOutEnN               = extReset ? {PORT_W{1'b1}} : '0;
		portOutForce             = '0;
		if (extReset) begin
			portOutEnN[LOW_PIN]  = 1'b0;
		end
	end

	assign clockMonitorEnable = clkEn_q;
	assign resetCauseFlags    = flags_q;

	// checker helper: run of low samples on the filtered pin, counted apart from the filter
	always_comb begin
		if (pinN) lowRun_d = '0;
		else if (lowRun_q == CNT_MAX) lowRun_d = CNT_MAX;
		else lowRun_d = lowRun_q + CW'(1);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) lowRun_q <= '0;
		else lowRun_q <= lowRun_d;
	end

	sequence s_extTaken;
		$rose(extReset);
	endsequence

	sequence s_pinHeldFull;
		lowRun_q == CNT_MAX;
	endsequence

	sequence s_monFail;
		clockMonFail;
	endsequence

	sequence s_monRecorded;
		!clockMonitorEnable && resetCauseFlags[CAUSE_CLKMON];
	endsequence

	property p_osc_stop;
		@(posedge ref_clk) disable iff (!rstn)
		extReset |-> !crystalMainClockEn && !internalRingOscillatorEn;
	endproperty
	a_osc_stop: assert property (p_osc_stop)
		else $error("oscillators run during reset");

	property p_hold;
		@(posedge ref_clk) disable iff (!rstn)
		(extReset && standbyActive) |-> standbyHold;
	endproperty
	a_hold: assert property (p_hold)
		else $error("standby not held");

	property p_pins;
		@(posedge ref_clk) disable iff (!rstn)
		extReset |-> !portOutEnN[LOW_PIN] && !portOutForce[LOW_PIN] && ($countones(portOutEnN) == PORT_W-1);
	endproperty
	a_pins: assert property (p_pins)
		else $error("port pin state wrong in reset");

	property p_svd;
		@(posedge ref_clk) disable iff (!rstn)
		(supplyDetReset && !extReset) |-> supplyDetResetN && !sysResetN;
	endproperty
	a_svd: assert property (p_svd)
		else $error("detector reset wrong");

	property p_wdt;
		@(posedge ref_clk) disable iff (!rstn)
		watchdogOverflow |-> !watchdogResetN;
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog not reset");

	property p_sticky;
		@(posedge ref_clk) disable iff (!rstn)
		(clockMonitorEnable && !extReset && !intReset) |=> clockMonitorEnable;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("enable cleared by software");

	property p_clkmon;
		@(posedge ref_clk) disable iff (!rstn)
		s_monFail |=> s_monRecorded;
	endproperty
	a_clkmon: assert property (p_clkmon)
		else $error("clock monitor reset not recorded");

	property p_minw;
		@(posedge ref_clk) disable iff (!rstn)
		s_extTaken |-> s_pinHeldFull;
	endproperty
	a_minw: assert property (p_minw)
		else $error("reset taken without minimum width");

	// cause flags only ever set while out of power-on-clear
	property p_flags_keep;
		@(posedge ref_clk) disable iff (!rstn)
		(resetCauseFlags & $past(resetCauseFlags)) == $past(resetCauseFlags);
	endproperty
	a_flags_keep: assert property (p_flags_keep)
		else $error("cause flag cleared without power-on-clear");
endmodule
`default_nettype wire

/* tb/rsc_ext_src.sv */
/* external reset source model driving the reset pin.
   assumes ref_clk of the design; pin idles high (pull-up) */
`timescale 1ns/1ps
`default_nettype none
module rsc_ext_src (
	input  wire logic ref_clk,
	output logic      extResetPinN
);
	initial extResetPinN = 1'b1;
	// lengths below the minimum only when a refusal is wanted
	task automatic hold_low(input int n);
		@(posedge ref_clk) extResetPinN <= 1'b0;
		repeat (n) @(posedge ref_clk);
		extResetPinN <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* tb/rsc_reset_ctrl_bench.sv */
/* bench for rsc_reset_ctrl: reset sources, pins, sticky enable, flags.
   assumes MIN_CYC shortened to 8, port width 8, low pin 0 */
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_bench;
	import rsc_pkg::*;
	localparam int MINC = 8;
	localparam logic [7:0] ALL_FLAGS = (8'h01 << CAUSE_WDT) | (8'h01 << CAUSE_CLKMON) | (8'h01 << CAUSE_SVD);
	logic       ref_clk, rstn, supplyDetReset, watchdogOverflow, clockMonFail;
	logic       standbyActive, clkMonWrite, clkMonWdata;
	wire logic  extResetPinN, sysResetN, watchdogResetN, supplyDetResetN, standbyHold;
	wire logic  crystalMainClockEn, internalRingOscillatorEn, clockMonitorEnable;
	wire logic [7:0] portOutEnN, portOutForce, resetCauseFlags;
	int         failCount = 0;
	int         totalChecks = 0;
	rsc_ext_src src (.ref_clk, .extResetPinN);
	rsc_reset_ctrl #(.PORT_W(8), .LOW_PIN(0), .MIN_CYC(MINC)) dut (.ref_clk, .rstn, .extResetPinN,
		.supplyDetReset, .watchdogOverflow, .clockMonFail, .standbyActive, .clkMonWrite,
		.clkMonWdata, .sysResetN, .watchdogResetN, .supplyDetResetN, .standbyHold,
		.crystalMainClockEn, .internalRingOscillatorEn, .portOutEnN, .portOutForce,
		.clockMonitorEnable, .resetCauseFlags);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chkBit(input logic got, input logic exp);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected at %0t: bit %b want %b", $time, got, exp);
		end
	endtask
	task automatic chkVec(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic printVerdict;
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tWdt;
		@(posedge ref_clk) watchdogOverflow <= 1'b1;
		#1 chkBit(watchdogResetN, 1'b0);
		chkBit(sysResetN, 1'b0);
		@(posedge ref_clk) watchdogOverflow <= 1'b0;
		#1 chkBit(watchdogResetN, 1'b1);
		chkVec(resetCauseFlags, 8'h01 << CAUSE_WDT);
	endtask
	task automatic tSvd;
		@(posedge ref_clk) supplyDetReset <= 1'b1;
		#1 chkBit(sysResetN, 1'b0);
		chkBit(supplyDetResetN, 1'b1);
		@(posedge ref_clk) supplyDetReset <= 1'b0;
		#1 chkBit(sysResetN, 1'b1);
		chkVec(resetCauseFlags, (8'h01 << CAUSE_WDT) | (8'h01 << CAUSE_SVD));
	endtask
	task automatic tClkMon;
		@(posedge ref_clk) {clkMonWrite, clkMonWdata} <= 2'b11;
		@(posedge ref_clk) clkMonWdata <= 1'b0;
		@(posedge ref_clk) clkMonWrite <= 1'b0;
		#1 chkBit(clockMonitorEnable, 1'b1);
		@(posedge ref_clk) clockMonFail <= 1'b1;
		@(posedge ref_clk) clockMonFail <= 1'b0;
		#1 chkBit(clockMonitorEnable, 1'b0);
		chkVec(resetCauseFlags, ALL_FLAGS);
	endtask
	task automatic tExt;
		int n;
		@(posedge ref_clk) {standbyActive, clkMonWrite, clkMonWdata} <= 3'b111;
		@(posedge ref_clk) clkMonWrite <= 1'b0;
		// one cycle short of the minimum must be ignored
		src.hold_low(MINC - 1);
		repeat (16) begin
			@(posedge ref_clk);
			#1 chkBit(sysResetN, 1'b1);
		end
		chkBit(clockMonitorEnable, 1'b1);
		fork
			src.hold_low(30);
		join_none
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (sysResetN !== 1'b0 && n < 40);
		// pin low at least MINC cycles, plus sync and filter latency
		chkBit(n > MINC && n < MINC + 7, 1'b1);
		chkBit(crystalMainClockEn, 1'b0);
		chkBit(internalRingOscillatorEn, 1'b0);
		chkBit(standbyHold, 1'b1);
		chkBit(supplyDetResetN, 1'b0);
		chkVec(portOutEnN, 8'hFE);
		chkVec(portOutForce, 8'h00);
		repeat (40) @(posedge ref_clk);
		#1 chkBit(sysResetN, 1'b1);
		chkBit(crystalMainClockEn, 1'b1);
		chkBit(standbyHold, 1'b0);
		chkVec(portOutEnN, 8'h00);
		chkBit(clockMonitorEnable, 1'b0);
		chkVec(resetCauseFlags, ALL_FLAGS);
	endtask
	task automatic tPoc;
		@(posedge ref_clk) {clkMonWrite, clkMonWdata} <= 2'b11;
		@(posedge ref_clk) clkMonWrite <= 1'b0;
		#1 chkBit(clockMonitorEnable, 1'b1);
		@(posedge ref_clk) rstn <= 1'b0;
		#1 chkVec(resetCauseFlags, FLAGS_RESET);
		chkBit(clockMonitorEnable, 1'b0);
		@(posedge ref_clk) rstn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 chkBit(sysResetN, 1'b1);
		chkVec(resetCauseFlags, FLAGS_RESET);
		chkVec(portOutEnN, 8'h00);
	endtask
	initial begin
		{rstn, supplyDetReset, watchdogOverflow, clockMonFail} = 4'h0;
		{standbyActive, clkMonWrite, clkMonWdata} = 3'h0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		tWdt;
		tSvd;
		tClkMon;
		tExt;
		tPoc;
		printVerdict;
	end
	// run needs about a hundred cycles
	initial begin
		#20000;
		failCount++;
		printVerdict;
	end
endmodule
`default_nettype wire
